//--- logic/esp_core_state.sv
// Overview of operation
// RL1 - application reads of the execution state return zero
// RL2 - application writes of the execution state are ignored
// RL3 - interrupt in a multiple transfer records next operand in bits 15:12
// RL4 - after servicing, the transfer resumes at the recorded operand
// RL5 - resume state keeps bits 26:25 and 11:10 at zero
// RL6 - conditional block covers at most four instructions, condition or inverse
// RL7 - exchange branches and pop to pc may clear the state bit
// RL8 - exception return reloads state bit; entry or reset use vector bit 0 (reset here clears the bit to 0)
// RL9 - executing with the state bit clear raises a fault
// RL10 - bottom-top pack: low of first, high of shifted second
// RL11 - top-bottom pack: high of first, low of shifted second
// RL12 - bottom-top shift is logical left 0 to 31
// RL13 - top-bottom shift is arithmetic right, zero field meaning 32
// RL14 - software must not target stack pointer or pc with packs
// RL15 - packs and block opening leave condition flags unchanged
// RL16 - conditional instructions other than branch belong in a block
// RL17 - a branch in a block must be its last instruction
// RL18 - scalar saturating ops may set sticky saturation, lane forms do not
// RL19 - multiply-accumulate keeps flags; flag-setting multiply updates n and z
// RL20 - block state advances per instruction and clears after the last
`timescale 1ns/1ps
`default_nettype none
module esp_core_state
  import esp_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // instruction issue
  input  wire logic        issue,
  input  wire logic [3:0]  op,
  input  wire logic [31:0] opa,
  input  wire logic [31:0] opb,
  input  wire logic [31:0] opc,
  input  wire logic [4:0]  shamt,
  input  wire logic [7:0]  block_code,
  input  wire logic        branch_exchange,
  input  wire logic [31:0] branch_target,
  // multiple transfer progress
  input  wire logic        multi_active,
  input  wire logic [3:0]  multi_next_reg,
  input  wire logic        irq_take,
  // exception entry and return
  input  wire logic        exc_entry,
  input  wire logic [31:0] vector_value,
  input  wire logic        exc_return,
  input  wire logic [31:0] stacked_status,
  // special register access path
  input  wire logic        sr_read,
  input  wire logic        sr_write,
  input  wire logic [31:0] sr_wdata,
  // results
  output logic [31:0]      sr_rdata,
  output logic [31:0]      exec_state,
  output logic [31:0]      result,
  output logic             result_valid,
  output logic             flag_n,
  output logic             flag_z,
  output logic             flag_c,
  output logic             flag_v,
  output logic             flag_q,
  output logic             fault,
  output logic [3:0]       resume_reg,
  output logic             resume_valid,
  output logic             in_block,
  output logic             cond_invert
);

  logic [31:0] dp_result;
  logic        dp_sat;
  logic        isa_state;
  logic [7:0]  block_state;
  logic [3:0]  resume_operand_field;
  logic        resume_mode;
  logic        execute_ok;
  logic [7:0]  next_block_state;
  logic        block_base;
  logic        next_block_base;
  logic [2:0]  block_count;

  esp_datapath u_dp (
    .op      (op),
    .opa     (opa),
    .opb     (opb),
    .opc     (opc),
    .shamt   (shamt),
    .result  (dp_result),
    .sat_hit (dp_sat)
  );

  // only a valid state bit lets an instruction execute
  assign execute_ok = issue && isa_state;

  // state bit: exception return, entry and exchange branches
  always_ff @(posedge clk)
  begin
    if (rst)
      isa_state <= 1'b0;
    else if (exc_return)
      isa_state <= stacked_status[ESP_ISA_BIT]; // RL8
    else if (exc_entry)
      isa_state <= vector_value[0]; // RL8
    else if (execute_ok && branch_exchange)
      isa_state <= branch_target[0]; // RL7
  end

  // fault when issue attempted with the state bit clear
  always_ff @(posedge clk)
  begin
    if (rst)
      fault <= 1'b0;
    else
      fault <= issue && !isa_state && !exc_entry && !exc_return; // RL9
  end

  // next block state: shift mask, clear when exhausted
  always_comb
  begin
    next_block_state = block_state;
    next_block_base  = block_base;
    if (execute_ok && op == ESP_OP_BLOCK_OPEN)
    begin
      next_block_state = block_code; // RL6
      next_block_base  = block_code[4]; // RL6
    end
    else if (execute_ok && block_state[3:0] != 4'h0)
    begin
      if (block_state[2:0] == 3'h0)
        next_block_state = 8'h00; // RL20
      else
        next_block_state = {block_state[7:5],
                            block_state[3:0], 1'b0}; // RL20
    end
  end

  // conditional block state; a stacked word restores it on return
  always_ff @(posedge clk)
  begin
    if (rst)
      block_state <= 8'h00;
    else if (exc_return)
      block_state <= {stacked_status[15:10], stacked_status[26:25]};
    else if (exc_entry || irq_take)
      block_state <= 8'h00;
    else
      block_state <= next_block_state;
  end

  // base condition bit of the open block; a return cannot recover the
  // original one, so the resumed instruction becomes the reference
  always_ff @(posedge clk)
  begin
    if (rst)
      block_base <= 1'b0;
    else if (exc_return)
      block_base <= stacked_status[ESP_MID_LSB + 2]; // RL6
    else
      block_base <= next_block_base;
  end

  // instructions run in the open block, kept only for the length check
  always_ff @(posedge clk)
  begin
    if (rst)
      block_count <= 3'h0;
    else if (exc_return || exc_entry || irq_take)
      block_count <= 3'h0;
    else if (execute_ok && op == ESP_OP_BLOCK_OPEN)
      block_count <= 3'h0;
    else if (execute_ok && block_state[3:0] != 4'h0)
      block_count <= block_count + 3'h1;
  end

  // resume field capture on interrupt, consumed on resumption
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      resume_operand_field <= 4'h0;
      resume_mode          <= 1'b0;
    end
    else if (irq_take && multi_active)
    begin
      resume_operand_field <= multi_next_reg; // RL3
      resume_mode          <= 1'b1;
    end
    else if (exc_return && stacked_status[ESP_RESUME_LSB +: 4] != 4'h0 &&
             stacked_status[ESP_HI_LSB +: 2] == 2'b00)
    begin
      resume_operand_field <= stacked_status[ESP_RESUME_LSB +: 4]; // RL4
      resume_mode          <= 1'b1;
    end
    else if (execute_ok && multi_active && resume_mode)
      resume_mode <= 1'b0; // RL4
  end

  // visible execution state; resume mode zeroes the block bits except 15:12, which carry the operand field
  always_ff @(posedge clk)
  begin
    if (rst)
      exec_state <= ESP_RESET_VALUE;
    else if (resume_mode && !(exc_return))
      exec_state <= {5'h00, 2'b00, isa_state, 8'h00,
                     resume_operand_field, 2'b00, 10'h000}; // RL5
    else
      exec_state <= {5'h00, next_block_state[1:0], isa_state, 8'h00,
                     next_block_state[7:2], 10'h000};
  end

  // application reads always see zero
  always_ff @(posedge clk)
  begin
    if (rst)
      sr_rdata <= 32'h0000_0000;
    else if (sr_read)
      sr_rdata <= 32'h0000_0000; // RL1
    else
      sr_rdata <= 32'h0000_0000;
  end

  // sr_write and sr_wdata are deliberately not connected to any state
  logic unused_sr;
  assign unused_sr = sr_write ^ (^sr_wdata); // RL2

  // resume handshake towards the transfer sequencer
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      resume_reg   <= 4'h0;
      resume_valid <= 1'b0;
    end
    else
    begin
      resume_reg   <= resume_operand_field; // RL4
      resume_valid <= resume_mode;
    end
  end

  // block status outputs
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      in_block    <= 1'b0;
      cond_invert <= 1'b0;
    end
    else
    begin
      in_block    <= next_block_state[3:0] != 4'h0; // RL6
      cond_invert <= next_block_state[3:0] != 4'h0 &&
                     next_block_state[4] != next_block_base; // RL6
    end
  end

  // datapath result register
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      result       <= 32'h0000_0000;
      result_valid <= 1'b0;
    end
    else
    begin
      result       <= dp_result;
      result_valid <= execute_ok && op != ESP_OP_NONE &&
                      op != ESP_OP_BLOCK_OPEN;
    end
  end

  // flags: only flag-setting multiply touches n and z
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      flag_n <= 1'b0;
      flag_z <= 1'b0;
      flag_c <= 1'b0;
      flag_v <= 1'b0;
    end
    else if (execute_ok && op == ESP_OP_MULS) // RL15
    begin
      flag_n <= dp_result[31]; // RL19
      flag_z <= dp_result == 32'h0000_0000; // RL19
    end
  end

  // sticky saturation; lane forms never set it
  always_ff @(posedge clk)
  begin
    if (rst)
      flag_q <= 1'b0;
    else if (execute_ok && dp_sat && op >= ESP_OP_SATURATING_ADD &&
             op <= ESP_OP_SATURATING_DOUBLE_SUBTRACT)
      flag_q <= 1'b1; // RL18
  end

  // checks
  AST_READ_ZERO: assert property (@(posedge clk) disable iff (rst) // RL1
    $past(sr_read) |-> sr_rdata == 32'h0000_0000)
    else $error("read path not zero");
  AST_WRITE_IGNORED: assert property (@(posedge clk) disable iff (rst) // RL2
    sr_write && !exc_return && !exc_entry && !issue && !irq_take
    |=> $stable(isa_state))
    else $error("write changed state");
  AST_RESUME_CAPTURE: assert property (@(posedge clk) disable iff (rst) // RL3
    irq_take && multi_active |=> ##1 resume_reg == $past(multi_next_reg, 2)
    && resume_valid)
    else $error("resume field not captured");
  AST_RESUME_ZERO: assert property (@(posedge clk) disable iff (rst) // RL5
    $past(resume_mode) && !$past(exc_return) |->
    exec_state[26:25] == 2'b00 && exec_state[11:10] == 2'b00)
    else $error("resume state bits nonzero");
  AST_ENTRY_VEC: assert property (@(posedge clk) disable iff (rst) // RL8
    exc_entry && !exc_return |=> isa_state == $past(vector_value[0]))
    else $error("entry state bit wrong");
  AST_FAULT: assert property (@(posedge clk) disable iff (rst) // RL9
    issue && !isa_state && !exc_entry && !exc_return |=> fault)
    else $error("no fault on bad state");
  AST_BLOCK_LEN: assert property (@(posedge clk) disable iff (rst) // RL20
    execute_ok && op == ESP_OP_BLOCK_OPEN && block_code[3:0] != 4'h0
    && !exc_return && !exc_entry && !irq_take
    |-> ##[1:5] block_state[3:0] == 4'h0 || irq_take || exc_entry ||
    exc_return || op == ESP_OP_BLOCK_OPEN || !execute_ok)
    else $error("block longer than four");
  AST_BLOCK_COUNT: assert property (@(posedge clk) disable iff (rst) // RL6
    block_state[3:0] != 4'h0 |-> block_count < 3'h4)
    else $error("block ran past four instructions");
  AST_FLAGS_KEEP: assert property (@(posedge clk) disable iff (rst) // RL15
    op != ESP_OP_MULS |=> $stable(flag_n) && $stable(flag_z))
    else $error("flags changed");
  AST_Q_LANE: assert property (@(posedge clk) disable iff (rst) // RL18
    !flag_q && op == ESP_OP_QLANE |=> !flag_q)
    else $error("lane op set q");
  AST_PACK_BT: assert property (@(posedge clk) disable iff (rst) // RL10
    op == ESP_OP_PACK_BT |=> result[15:0] == $past(opa[15:0]))
    else $error("pack bt low half wrong");

  COV_BLOCK: cover property (@(posedge clk) execute_ok &&
    op == ESP_OP_BLOCK_OPEN ##1 in_block);
  COV_RESUME: cover property (@(posedge clk) irq_take && multi_active);
  COV_Q: cover property (@(posedge clk) $rose(flag_q));
  COV_FAULT: cover property (@(posedge clk) $rose(fault));
  COV_INVERT: cover property (@(posedge clk) $rose(cond_invert));

endmodule : esp_core_state
`default_nettype wire

//--- logic/esp_datapath.sv
`timescale 1ns/1ps
`default_nettype none
module esp_datapath
  import esp_pkg::*;
(
  // operation and operands
  input  wire logic [3:0]  op,
  input  wire logic [31:0] opa,
  input  wire logic [31:0] opb,
  input  wire logic [31:0] opc,
  input  wire logic [4:0]  shamt,
  // combinational result
  output logic [31:0]      result,
  output logic             sat_hit
);

  // signed saturation of a 33-bit value to 32 bits
  function automatic logic [32:0] sat32(input logic [32:0] v);
    logic [32:0] r;
    r = v;
    if (v[32] != v[31])
      r = v[32] ? {1'b1, 32'h8000_0000} : {1'b0, 32'h7fff_ffff};
    return r;
  endfunction : sat32

  logic [31:0] sh_bt;
  logic [31:0] sh_tb;
  logic [32:0] dbl;
  logic [32:0] raw;
  logic [32:0] sat;
  logic        dbl_sat;
  logic [63:0] prod;

  // pack shifts: a zero asr field means a full 32-bit shift
  always_comb
  begin
    sh_bt = opb << shamt; // RL12
    if (shamt == ESP_ASR_ZERO_ENC)
      sh_tb = {32{opb[31]}}; // RL13
    else
      sh_tb = $signed(opb) >>> shamt; // RL13
  end

  // saturating arithmetic and multiply
  always_comb
  begin
    dbl     = sat32({opb[31], opb[30:0], 1'b0});
    dbl_sat = (opb[31] != opb[30]);
    prod    = opa * opb;
    raw     = 33'h0_0000_0000;
    sat     = 33'h0_0000_0000;
    result  = 32'h0000_0000;
    sat_hit = 1'b0;
    case (op)
      ESP_OP_PACK_BT: result = {sh_bt[31:16], opa[15:0]}; // RL10
      ESP_OP_PACK_TB: result = {opa[31:16], sh_tb[15:0]}; // RL11
      ESP_OP_SATURATING_ADD, ESP_OP_SATURATING_DOUBLE_ADD, ESP_OP_SATURATING_SUBTRACT, ESP_OP_SATURATING_DOUBLE_SUBTRACT:
      begin
        if (op == ESP_OP_SATURATING_ADD)
          raw = {opa[31], opa} + {opb[31], opb};
        else if (op == ESP_OP_SATURATING_SUBTRACT)
          raw = {opa[31], opa} - {opb[31], opb};
        else if (op == ESP_OP_SATURATING_DOUBLE_ADD)
          raw = {opa[31], opa} + {dbl[31], dbl[31:0]};
        else
          raw = {opa[31], opa} - {dbl[31], dbl[31:0]};
        sat     = sat32(raw);
        result  = sat[31:0];
        sat_hit = (raw[32] != raw[31]) ||
                  (dbl_sat && (op == ESP_OP_SATURATING_DOUBLE_ADD || op == ESP_OP_SATURATING_DOUBLE_SUBTRACT));
      end
      ESP_OP_MUL, ESP_OP_MULS: result = prod[31:0]; // RL19
      ESP_OP_MLA: result = opc + prod[31:0]; // RL19
      ESP_OP_MLS: result = opc - prod[31:0]; // RL19
      default: result = 32'h0000_0000;
    endcase
  end

endmodule : esp_datapath
`default_nettype wire

//--- logic/esp_pkg.sv
package esp_pkg;

  // execution state word layout
  localparam int unsigned ESP_RESET_VALUE  = 32'h0000_0000;
  localparam int unsigned ESP_ISA_BIT      = 24;
  localparam int unsigned ESP_HI_LSB       = 25;
  localparam int unsigned ESP_MID_LSB      = 10;
  localparam int unsigned ESP_RESUME_LSB   = 12;
  localparam int unsigned ESP_BLOCK_MAX    = 4;
  localparam logic [4:0]  ESP_ASR_ZERO_ENC = 5'h00;

  // instruction operation selects
  typedef enum logic [3:0] {
    ESP_OP_NONE,
    ESP_OP_PACK_BT,
    ESP_OP_PACK_TB,
    ESP_OP_SATURATING_ADD,
    ESP_OP_SATURATING_SUBTRACT,
    ESP_OP_SATURATING_DOUBLE_ADD,
    ESP_OP_SATURATING_DOUBLE_SUBTRACT,
    ESP_OP_QLANE,
    ESP_OP_MUL,
    ESP_OP_MULS,
    ESP_OP_MLA,
    ESP_OP_MLS,
    ESP_OP_BLOCK_OPEN
  } esp_op_e;

endpackage : esp_pkg

//--- test/esp_core_state_test.sv
`timescale 1ns/1ps
`default_nettype none
module esp_core_state_test;
  import esp_pkg::*;
  // stimulus
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        issue = 1'b0;
  logic [3:0]  op = 4'h0;
  logic [31:0] opa = 32'h0000_0000;
  logic [31:0] opb = 32'h0000_0000;
  logic [31:0] opc = 32'h0000_0000;
  logic [4:0]  shamt = 5'h00;
  logic [7:0]  block_code = 8'h00;
  logic        branch_exchange = 1'b0;
  logic [31:0] branch_target = 32'h0000_0000;
  logic        multi_active = 1'b0;
  logic [3:0]  multi_next_reg = 4'h0;
  logic        irq_take = 1'b0;
  logic        exc_entry = 1'b0;
  logic [31:0] vector_value = 32'h0000_0000;
  logic        exc_return = 1'b0;
  logic [31:0] stacked_status = 32'h0000_0000;
  logic        sr_read = 1'b0;
  logic        sr_write = 1'b0;
  logic [31:0] sr_wdata = 32'h0000_0000;
  // observed
  logic [31:0] sr_rdata, exec_state, result, saved;
  logic        result_valid, flag_n, flag_z, flag_c, flag_v, flag_q;
  logic        fault, resume_valid, in_block, cond_invert;
  logic [3:0]  resume_reg;
  int          failures = 0;
  int          check_count = 0;

  esp_core_state uut (.clk(clk), .rst(rst), .issue(issue), .op(op),
    .opa(opa), .opb(opb), .opc(opc), .shamt(shamt),
    .block_code(block_code), .branch_exchange(branch_exchange),
    .branch_target(branch_target), .multi_active(multi_active),
    .multi_next_reg(multi_next_reg), .irq_take(irq_take),
    .exc_entry(exc_entry), .vector_value(vector_value),
    .exc_return(exc_return), .stacked_status(stacked_status),
    .sr_read(sr_read), .sr_write(sr_write), .sr_wdata(sr_wdata),
    .sr_rdata(sr_rdata), .exec_state(exec_state), .result(result),
    .result_valid(result_valid), .flag_n(flag_n), .flag_z(flag_z),
    .flag_c(flag_c), .flag_v(flag_v), .flag_q(flag_q), .fault(fault),
    .resume_reg(resume_reg), .resume_valid(resume_valid),
    .in_block(in_block), .cond_invert(cond_invert));

  // 200 MHz core clock
  initial
  begin
    forever #2.5 clk = ~clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string what);
    check_count++;
    if (got !== exp)
    begin
      failures++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : give_verdict

  // one issued operation; result, flags, fault and block outputs are settled just after the edge that takes it
  task automatic run_op(input esp_op_e o, input logic [31:0] a,
                        input logic [31:0] b, input logic [31:0] c,
                        input logic [4:0] s);
    @(posedge clk);
    issue <= 1'b1;
    op <= o;
    opa <= a;
    opb <= b;
    opc <= c;
    shamt <= s;
    @(posedge clk);
    issue <= 1'b0;
    branch_exchange <= 1'b0;
    #1;
  endtask : run_op

  // exception entry with a vector, or return with a stacked word
  task automatic exc(input logic ret, input logic [31:0] v);
    @(posedge clk);
    exc_entry <= ~ret;
    exc_return <= ret;
    vector_value <= v;
    stacked_status <= v;
    @(posedge clk);
    exc_entry <= 1'b0;
    exc_return <= 1'b0;
    // the visible state word follows the state bit one edge later
    @(posedge clk);
    #1;
  endtask : exc

  task automatic t_reset_and_sr();
    chk(exec_state, 32'h0000_0000, "reset state");
    run_op(ESP_OP_MULS, 32'h0000_0002, 32'h0000_0003, 32'h0, 5'h00);
    chk(32'(fault), 32'h1, "fault with bit clear");
    chk(32'(result_valid), 32'h0, "no result when refused");
    exc(1'b0, 32'h0000_0001);
    chk(32'(exec_state[24]), 32'h1, "entry loads bit");
    saved = exec_state;
    @(posedge clk);
    sr_read <= 1'b1;
    sr_write <= 1'b1;
    sr_wdata <= 32'hFFFF_FFFF;
    @(posedge clk);
    sr_read <= 1'b0;
    sr_write <= 1'b0;
    #1;
    chk(sr_rdata, 32'h0000_0000, "special read");
    chk(exec_state, saved, "special write ignored");
    $display("test reset_and_sr done");
  endtask : t_reset_and_sr

  task automatic t_mul();
    run_op(ESP_OP_MULS, 32'hFFFF_FFFE, 32'h0000_0003, 32'h0, 5'h00);
    chk(result, 32'hFFFF_FFFA, "muls result");
    chk(32'({result_valid, flag_n, flag_z}), 32'h6, "muls flags");
    run_op(ESP_OP_MLA, 32'h0000_0002, 32'h0000_0003, 32'h4, 5'h00);
    chk(result, 32'h0000_000A, "mla result");
    run_op(ESP_OP_MLS, 32'h0000_0002, 32'h0000_0003, 32'hA, 5'h00);
    chk(result, 32'h0000_0004, "mls result");
    chk(32'({flag_n, flag_z}), 32'h2, "mla mls keep flags");
    run_op(ESP_OP_MULS, 32'h0000_0000, 32'h0000_0005, 32'h0, 5'h00);
    chk(32'({flag_n, flag_z, flag_c, flag_v}), 32'h4, "muls zero");
    $display("test mul done");
  endtask : t_mul

  task automatic t_pack();
    run_op(ESP_OP_PACK_BT, 32'h1234_5678, 32'hABCD_0000, 32'h0, 5'h00);
    chk(result, 32'hABCD_5678, "bt unshifted");
    run_op(ESP_OP_PACK_BT, 32'h1234_5678, 32'h0000_ABCD, 32'h0, 5'h10);
    chk(result, 32'hABCD_5678, "bt shift 16");
    run_op(ESP_OP_PACK_BT, 32'h1234_5678, 32'h0000_0001, 32'h0, 5'h1F);
    chk(result, 32'h8000_5678, "bt shift 31");
    run_op(ESP_OP_PACK_TB, 32'h1234_5678, 32'h8000_0000, 32'h0, 5'h00);
    chk(result, 32'h1234_FFFF, "tb zero field is 32");
    run_op(ESP_OP_PACK_TB, 32'h1234_5678, 32'h0002_4680, 32'h0, 5'h01);
    chk(result, 32'h1234_2340, "tb shift 1");
    chk(32'({flag_n, flag_z}), 32'h1, "pack keeps flags");
    $display("test pack done");
  endtask : t_pack

  task automatic t_sat();
    run_op(ESP_OP_QLANE, 32'h7FFF_7FFF, 32'h0001_0001, 32'h0, 5'h00);
    chk(32'(flag_q), 32'h0, "lane form leaves q");
    run_op(ESP_OP_SATURATING_DOUBLE_ADD, 32'h0000_0002, 32'h0000_0002, 32'h0, 5'h00);
    chk(result, 32'h0000_0006, "saturating_double_add");
    run_op(ESP_OP_SATURATING_DOUBLE_SUBTRACT, 32'h0000_0002, 32'h0000_0002, 32'h0, 5'h00);
    chk(result, 32'hFFFF_FFFE, "saturating_double_subtract");
    chk(32'(flag_q), 32'h0, "no saturation no q");
    run_op(ESP_OP_SATURATING_SUBTRACT, 32'h8000_0000, 32'h0000_0001, 32'h0, 5'h00);
    chk(result, 32'h8000_0000, "saturating_subtract saturates");
    chk(32'(flag_q), 32'h1, "saturating_subtract sets q");
    run_op(ESP_OP_SATURATING_ADD, 32'h7FFF_FFFF, 32'h0000_0001, 32'h0, 5'h00);
    chk(result, 32'h7FFF_FFFF, "saturating_add saturates");
    $display("test sat done");
  endtask : t_sat

  // then, then, else, else: a block of the full four instructions
  task automatic t_block();
    @(posedge clk);
    block_code <= 8'h07;
    run_op(ESP_OP_BLOCK_OPEN, 32'h0, 32'h0, 32'h0, 5'h00);
    chk(32'({in_block, cond_invert}), 32'h2, "block opened");
    chk(32'({flag_n, flag_z}), 32'h1, "open keeps flags");
    for (int i = 0; i < 3; i++)
    begin
      run_op(ESP_OP_MLA, 32'h1, 32'h1, 32'h0, 5'h00);
      chk(32'({in_block, cond_invert}), (i == 0) ? 32'h2 : 32'h3,
          "still in block");
    end
    run_op(ESP_OP_MLA, 32'h1, 32'h1, 32'h0, 5'h00);
    chk(32'({in_block, cond_invert}), 32'h0,
        "block closed after four");
    $display("test block done");
  endtask : t_block

  task automatic t_resume();
    @(posedge clk);
    multi_active <= 1'b1;
    multi_next_reg <= 4'h9;
    irq_take <= 1'b1;
    @(posedge clk);
    irq_take <= 1'b0;
    // the captured field reaches the outputs one edge after the capture
    @(posedge clk);
    #1;
    chk(32'(exec_state[15:12]), 32'h9, "next operand kept");
    chk(32'({exec_state[26:25], exec_state[11:10]}), 32'h0,
        "resume zero bits");
    chk(32'({resume_valid, resume_reg}), 32'h19, "resume offered");
    run_op(ESP_OP_MLA, 32'h1, 32'h1, 32'h0, 5'h00);
    @(posedge clk);
    multi_active <= 1'b0;
    #1;
    chk(32'(resume_valid), 32'h0, "resume consumed");
    $display("test resume done");
  endtask : t_resume

  task automatic t_branch();
    @(posedge clk);
    branch_exchange <= 1'b1;
    branch_target <= 32'h0000_1000;
    run_op(ESP_OP_MLA, 32'h1, 32'h1, 32'h0, 5'h00);
    @(posedge clk);
    #1;
    chk(32'(exec_state[24]), 32'h0, "exchange clears bit");
    run_op(ESP_OP_MULS, 32'h1, 32'h1, 32'h0, 5'h00);
    chk(32'(fault), 32'h1, "fault after clear");
    exc(1'b1, 32'h0100_0000);
    chk(32'(exec_state[24]), 32'h1, "return reloads bit");
    exc(1'b0, 32'h0000_0100);
    chk(32'(exec_state[24]), 32'h0, "even vector clears bit");
    $display("test branch done");
  endtask : t_branch

  // watchdog well beyond the fewer than a hundred cycles the tests need
  initial
  begin
    #(5 * 4000);
    failures++;
    give_verdict();
  end

  initial
  begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    t_reset_and_sr();
    t_mul();
    t_pack();
    t_sat();
    t_block();
    t_resume();
    t_branch();
    give_verdict();
  end
endmodule : esp_core_state_test
`default_nettype wire
